// ==== pattern_gen_ctrl.sv ====
// Purpose: Test pattern generator control and pixel source for video output.
// Assumes: All inputs synchronous to ref_clk; frame_start marks each frame.
// Notes: Generated pixels replace received video while the generator runs.
//
// Contract
// RULE_01 - Generator runs while enable bit is 1, stops when it is 0.
// RULE_02 - Software powers down loop-through transmitter before enabling.
// RULE_03 - Control register reads 0x10 after reset.
// RULE_04 - Select field bits 7-4 chosen only without auto scrolling.
// RULE_05 - Ramps spread evenly over active width or height.
// RULE_06 - Each code gives one colour, or its complement when inverted.
// RULE_07 - Codes 1-5: white, black, red, green, blue solid fields.
// RULE_08 - Codes 6-9: horizontal ramps black to white, red, green, blue.
// RULE_09 - Code 10: vertical ramp black to white.
// RULE_10 - Software avoids reserved codes 0000 and 1111.
// RULE_11 - Compliance bit 3 forces compliance pattern, ignoring select.
// RULE_12 - Colour bar bit 2 gives eight bars white to black.
// RULE_13 - Band reverse bit 1 reorders quadrant bands.
// RULE_14 - Inversion bit inverts every generated colour.
// RULE_15 - Auto scroll steps pattern after programmed frame count.
// RULE_16 - Codes 11-13: vertical ramps black to red, green, blue.
// RULE_17 - Compliance beats colour bars, colour bars beat select field.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module pattern_gen_ctrl
#(
  parameter int H_ACTIVE = 640,
  parameter int V_ACTIVE = 480
)
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Received video and frame marker.
  input wire pattern_gen_pkg::video_t rx_video,
  input wire logic frame_start,
  // Video output.
  output pattern_gen_pkg::video_t tx_video
);

  localparam logic [15:0] h_width = 16'(H_ACTIVE);
  localparam logic [15:0] v_height = 16'(V_ACTIVE);

  // Register state.
  pattern_gen_pkg::ctrl_t ctrl_reg, ctrl_next;
  logic [1:0] cfg_reg, cfg_next;
  logic [7:0] frame_time_reg, frame_time_next;
  logic [7:0] rdata_reg, rdata_next;
  // Scroll state.
  logic [3:0] scroll_code_reg, scroll_code_next;
  logic [7:0] frame_cnt_reg, frame_cnt_next;
  // Raster state.
  logic de_prev_reg, de_prev_next;
  logic [15:0] hramp_acc_reg, hramp_acc_next;
  logic [7:0] hramp_reg, hramp_next;
  logic [15:0] bar_acc_reg, bar_acc_next;
  logic [2:0] bar_reg, bar_next;
  logic [15:0] vramp_acc_reg, vramp_acc_next;
  logic [7:0] vramp_reg, vramp_next;
  logic [15:0] band_acc_reg, band_acc_next;
  logic [1:0] band_reg, band_next;
  logic [3:0] x_reg, x_next;
  logic [3:0] y_reg, y_next;
  // Output state.
  pattern_gen_pkg::video_t video_reg, video_next;

  logic invert;
  logic scroll;
  logic [3:0] code;
  pattern_gen_pkg::rgb_t colour;

  assign invert = cfg_reg[pattern_gen_pkg::cfg_invert_bit];
  assign scroll = cfg_reg[pattern_gen_pkg::cfg_scroll_bit];
  assign reg_rdata = rdata_reg;
  assign tx_video = video_reg;

  // Register file and read-back.
  always_comb
  begin
    ctrl_next = ctrl_reg;
    cfg_next = cfg_reg;
    frame_time_next = frame_time_reg;
    rdata_next = 8'h00;
    if (reg_wr)
    begin
      unique case (reg_addr)
        pattern_gen_pkg::ctrl_addr: ctrl_next = reg_wdata;
        pattern_gen_pkg::cfg_addr: cfg_next = reg_wdata[1:0];
        pattern_gen_pkg::frame_time_addr: frame_time_next = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        pattern_gen_pkg::ctrl_addr: rdata_next = ctrl_reg;
        pattern_gen_pkg::cfg_addr: rdata_next = {6'h00, cfg_reg};
        pattern_gen_pkg::frame_time_addr: rdata_next = frame_time_reg;
        pattern_gen_pkg::status_addr:
          rdata_next = {code, 3'h0, ctrl_reg.pattern_generator_enable};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= pattern_gen_pkg::ctrl_reset; // RULE_03
      cfg_reg <= pattern_gen_pkg::cfg_reset;
      frame_time_reg <= pattern_gen_pkg::frame_time_reset;
      rdata_reg <= 8'h00;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      cfg_reg <= cfg_next;
      frame_time_reg <= frame_time_next;
      rdata_reg <= rdata_next;
    end
  end

  // Auto scroll walks codes 1 to 14, the last being the quadrant bands.
  always_comb
  begin
    scroll_code_next = scroll_code_reg;
    frame_cnt_next = frame_cnt_reg;
    if (!scroll)
    begin
      scroll_code_next = pattern_gen_pkg::code_first; // RULE_15
      frame_cnt_next = 8'h00;
    end
    else if (frame_start)
    begin
      // A frame time of zero behaves as one frame.
      if (frame_cnt_reg + 8'h01 >= frame_time_reg)
      begin
        frame_cnt_next = 8'h00;
        if (scroll_code_reg == pattern_gen_pkg::code_quadrant)
          scroll_code_next = pattern_gen_pkg::code_first; // RULE_15
        else
          scroll_code_next = scroll_code_reg + 4'h1; // RULE_15
      end
      else
        frame_cnt_next = frame_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scroll_code_reg <= pattern_gen_pkg::code_first;
      frame_cnt_reg <= 8'h00;
    end
    else
    begin
      scroll_code_reg <= scroll_code_next;
      frame_cnt_reg <= frame_cnt_next;
    end
  end

  assign code = scroll ? scroll_code_reg
                       : ctrl_reg.fixed_pattern_select; // RULE_04

  // Raster position held as error accumulators so that ramps, bars and
  // bands divide the active area evenly without a divider.
  always_comb
  begin
    de_prev_next = rx_video.de;
    hramp_acc_next = hramp_acc_reg;
    hramp_next = hramp_reg;
    bar_acc_next = bar_acc_reg;
    bar_next = bar_reg;
    vramp_acc_next = vramp_acc_reg;
    vramp_next = vramp_reg;
    band_acc_next = band_acc_reg;
    band_next = band_reg;
    x_next = x_reg;
    y_next = y_reg;
    if (rx_video.de)
    begin
      x_next = x_reg + 4'h1;
      hramp_acc_next = hramp_acc_reg + pattern_gen_pkg::ramp_step;
      if (hramp_acc_next >= h_width)
      begin
        hramp_acc_next = hramp_acc_next - h_width; // RULE_05
        hramp_next = hramp_reg + 8'h01;
      end
      bar_acc_next = bar_acc_reg + pattern_gen_pkg::bar_step;
      if (bar_acc_next >= h_width)
      begin
        bar_acc_next = bar_acc_next - h_width;
        bar_next = bar_reg + 3'h1;
      end
    end
    else if (de_prev_reg)
    begin
      x_next = 4'h0;
      hramp_acc_next = 16'h0000;
      hramp_next = 8'h00;
      bar_acc_next = 16'h0000;
      bar_next = 3'h0;
      y_next = y_reg + 4'h1;
      vramp_acc_next = vramp_acc_reg + pattern_gen_pkg::ramp_step;
      if (vramp_acc_next >= v_height)
      begin
        vramp_acc_next = vramp_acc_next - v_height; // RULE_05
        vramp_next = vramp_reg + 8'h01;
      end
      band_acc_next = band_acc_reg + pattern_gen_pkg::band_step;
      if (band_acc_next >= v_height)
      begin
        band_acc_next = band_acc_next - v_height;
        band_next = band_reg + 2'h1;
      end
    end
    if (frame_start)
    begin
      vramp_acc_next = 16'h0000;
      vramp_next = 8'h00;
      band_acc_next = 16'h0000;
      band_next = 2'h0;
      y_next = 4'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      de_prev_reg <= 1'b0;
      hramp_acc_reg <= 16'h0000;
      hramp_reg <= 8'h00;
      bar_acc_reg <= 16'h0000;
      bar_reg <= 3'h0;
      vramp_acc_reg <= 16'h0000;
      vramp_reg <= 8'h00;
      band_acc_reg <= 16'h0000;
      band_reg <= 2'h0;
      x_reg <= 4'h0;
      y_reg <= 4'h0;
    end
    else
    begin
      de_prev_reg <= de_prev_next;
      hramp_acc_reg <= hramp_acc_next;
      hramp_reg <= hramp_next;
      bar_acc_reg <= bar_acc_next;
      bar_reg <= bar_next;
      vramp_acc_reg <= vramp_acc_next;
      vramp_reg <= vramp_next;
      band_acc_reg <= band_acc_next;
      band_reg <= band_next;
      x_reg <= x_next;
      y_reg <= y_next;
    end
  end

  // Pattern colour before inversion.
  always_comb
  begin
    colour = '0;
    if (ctrl_reg.compliance_pattern_enable)
    begin
      // Black and white checkerboard of 8 by 8 pixel squares.
      if (x_reg[pattern_gen_pkg::checker_bit]
          ^ y_reg[pattern_gen_pkg::checker_bit])
        colour = '1; // RULE_11 RULE_17
    end
    else if (ctrl_reg.colour_bar_enable)
    begin
      unique case (bar_reg) // RULE_12 RULE_17
        3'h0: colour = {8'hff, 8'hff, 8'hff};
        3'h1: colour = {8'hff, 8'hff, 8'h00};
        3'h2: colour = {8'h00, 8'hff, 8'hff};
        3'h3: colour = {8'h00, 8'hff, 8'h00};
        3'h4: colour = {8'hff, 8'h00, 8'hff};
        3'h5: colour = {8'hff, 8'h00, 8'h00};
        3'h6: colour = {8'h00, 8'h00, 8'hff};
        3'h7: colour = {8'h00, 8'h00, 8'h00};
      endcase
    end
    else
    begin
      unique case (code) // RULE_06
        pattern_gen_pkg::code_white: colour = '1; // RULE_07
        pattern_gen_pkg::code_black: colour = '0; // RULE_07
        pattern_gen_pkg::code_red: colour.r = 8'hff; // RULE_07
        pattern_gen_pkg::code_green: colour.g = 8'hff; // RULE_07
        pattern_gen_pkg::code_blue: colour.b = 8'hff; // RULE_07
        pattern_gen_pkg::code_hramp_white:
          colour = {hramp_reg, hramp_reg, hramp_reg}; // RULE_08
        pattern_gen_pkg::code_hramp_red: colour.r = hramp_reg; // RULE_08
        pattern_gen_pkg::code_hramp_green: colour.g = hramp_reg; // RULE_08
        pattern_gen_pkg::code_hramp_blue: colour.b = hramp_reg; // RULE_08
        pattern_gen_pkg::code_vramp_white:
          colour = {vramp_reg, vramp_reg, vramp_reg}; // RULE_09
        pattern_gen_pkg::code_vramp_red: colour.r = vramp_reg; // RULE_16
        pattern_gen_pkg::code_vramp_green: colour.g = vramp_reg; // RULE_16
        pattern_gen_pkg::code_vramp_blue: colour.b = vramp_reg; // RULE_16
        pattern_gen_pkg::code_quadrant:
        begin
          // Bands from the top: yellow, cyan, blue, red, or blue, cyan, yellow, red when reversed.
          unique case ({ctrl_reg.quadrant_band_reverse, band_reg}) // RULE_13
            3'h0: colour = {8'hff, 8'hff, 8'h00};
            3'h1: colour = {8'h00, 8'hff, 8'hff};
            3'h2: colour = {8'h00, 8'h00, 8'hff};
            3'h3: colour = {8'hff, 8'h00, 8'h00};
            3'h4: colour = {8'h00, 8'h00, 8'hff};
            3'h5: colour = {8'h00, 8'hff, 8'hff};
            3'h6: colour = {8'hff, 8'hff, 8'h00};
            3'h7: colour = {8'hff, 8'h00, 8'h00};
          endcase
        end
        // Reserved codes give black; software must not use them.
        default: colour = '0; // RULE_10
      endcase
    end
  end

  // Output stage: one cycle of latency for both paths.
  always_comb
  begin
    video_next = rx_video;
    if (ctrl_reg.pattern_generator_enable) // RULE_01
    begin
      if (!rx_video.de)
        video_next.pix = '0;
      else if (invert)
        video_next.pix = ~colour; // RULE_14
      else
        video_next.pix = colour; // RULE_14
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      video_reg <= '0;
    else
      video_reg <= video_next;
  end

endmodule

// ==== pattern_gen_pkg.sv ====
// Purpose: Shared constants and types for the video test pattern control.
// Assumes: 8-bit register bus, 24-bit RGB pixels.
// Notes: Register offsets are byte addresses on the plain register port.
package pattern_gen_pkg;

  // Register offsets.
  localparam logic [7:0] ctrl_addr = 8'h64;
  localparam logic [7:0] cfg_addr = 8'h65;
  localparam logic [7:0] frame_time_addr = 8'h69;
  localparam logic [7:0] status_addr = 8'h6a;

  // Reset values.
  localparam logic [7:0] ctrl_reset = 8'h10;
  localparam logic [1:0] cfg_reset = 2'h0;
  localparam logic [7:0] frame_time_reset = 8'h3c;

  // Configuration field positions.
  localparam int cfg_invert_bit = 1;
  localparam int cfg_scroll_bit = 0;

  // Pattern codes.
  localparam logic [3:0] code_white = 4'h1;
  localparam logic [3:0] code_black = 4'h2;
  localparam logic [3:0] code_red = 4'h3;
  localparam logic [3:0] code_green = 4'h4;
  localparam logic [3:0] code_blue = 4'h5;
  localparam logic [3:0] code_hramp_white = 4'h6;
  localparam logic [3:0] code_hramp_red = 4'h7;
  localparam logic [3:0] code_hramp_green = 4'h8;
  localparam logic [3:0] code_hramp_blue = 4'h9;
  localparam logic [3:0] code_vramp_white = 4'ha;
  localparam logic [3:0] code_vramp_red = 4'hb;
  localparam logic [3:0] code_vramp_green = 4'hc;
  localparam logic [3:0] code_vramp_blue = 4'hd;
  localparam logic [3:0] code_quadrant = 4'he;
  localparam logic [3:0] code_first = 4'h1;

  // Ramp and band steps per pixel or per line.
  localparam logic [15:0] ramp_step = 16'h0100;
  localparam logic [15:0] bar_step = 16'h0008;
  localparam logic [15:0] band_step = 16'h0004;
  localparam int checker_bit = 3;

  typedef struct packed {
    logic [3:0] fixed_pattern_select;
    logic compliance_pattern_enable;
    logic colour_bar_enable;
    logic quadrant_band_reverse;
    logic pattern_generator_enable;
  } ctrl_t;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } rgb_t;

  typedef struct packed {
    logic de;
    logic hs;
    logic vs;
    rgb_t pix;
  } video_t;

endpackage

// ==== pattern_gen_ctrl_props.sv ====
// Purpose: Port checker for the test pattern control block.
// Assumes: Control and config writes are shadowed from the register port.
// Notes: Shadow copies keep the checks tied to what software asked for.
`timescale 1ns/100ps
module pattern_gen_ctrl_chk
#(
  parameter int H_ACTIVE = 640,
  parameter int V_ACTIVE = 480
)
(
  // Clock, reset and register port.
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Video.
  input wire pattern_gen_pkg::video_t rx_video,
  input wire logic frame_start,
  input wire pattern_gen_pkg::video_t tx_video
);
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [1:0] cfg_reg;
  logic [1:0] cfg_next;

  always_comb
  begin
    ctrl_next = ctrl_reg;
    cfg_next = cfg_reg;
    if (reg_wr && reg_addr == 8'h64)
      ctrl_next = reg_wdata;
    if (reg_wr && reg_addr == 8'h65)
      cfg_next = reg_wdata[1:0];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      ctrl_reg <= pattern_gen_pkg::ctrl_reset;
      cfg_reg <= pattern_gen_pkg::cfg_reset;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      cfg_reg <= cfg_next;
    end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_off_copy;
    !ctrl_reg[0] |=> tx_video == $past(rx_video);
  endproperty
  a_off_copy: assert property (p_off_copy)
    else $error("disabled output is not a copy");
  property p_blank;
    ctrl_reg[0] && !rx_video.de |=> !tx_video.de && tx_video.pix == 24'h0;
  endproperty
  a_blank: assert property (p_blank)
    else $error("blanking pixel not zero");
  property p_sync;
    ctrl_reg[0] |=> tx_video.hs == $past(rx_video.hs)
      && tx_video.vs == $past(rx_video.vs);
  endproperty
  a_sync: assert property (p_sync)
    else $error("syncs not passed through");
  property p_white;
    ctrl_reg == 8'h11 && cfg_reg == 2'h0 && rx_video.de
      |=> tx_video.pix == 24'hffffff;
  endproperty
  a_white: assert property (p_white)
    else $error("solid white wrong");
  property p_white_inv;
    ctrl_reg == 8'h11 && cfg_reg == 2'h2 && rx_video.de
      |=> tx_video.pix == 24'h0;
  endproperty
  a_white_inv: assert property (p_white_inv)
    else $error("inverted white wrong");
  property p_comp;
    ctrl_reg[3] && ctrl_reg[0] && cfg_reg == 2'h0 && rx_video.de
      |=> tx_video.pix == 24'h0 || tx_video.pix == 24'hffffff;
  endproperty
  a_comp: assert property (p_comp)
    else $error("compliance pixel not black or white");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_rd_ctrl;
    reg_rd && reg_addr == 8'h64 |=> reg_rdata == $past(ctrl_reg);
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl)
    else $error("control readback wrong");

  c_bars: cover property (ctrl_reg[2] && ctrl_reg[0] && rx_video.de);
  c_scroll: cover property (cfg_reg[0] && frame_start);
  c_quad: cover property (ctrl_reg == 8'he3 && rx_video.de);
endmodule

bind pattern_gen_ctrl pattern_gen_ctrl_chk
  #(.H_ACTIVE(H_ACTIVE), .V_ACTIVE(V_ACTIVE)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_video(rx_video),
  .frame_start(frame_start), .tx_video(tx_video));

// ==== tb.sv ====
// Purpose: Self-checking bench for the test pattern control block.
// Assumes: A 256 by 256 active area, so a ramp level equals x or y.
// Notes: Output pixels of the last line are captured at the falling edge.
`timescale 1ns/100ps
module tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  pattern_gen_pkg::video_t rx_video = {3'b000, 24'h5a5a5a};
  logic frame_start = 1'b0;
  pattern_gen_pkg::video_t tx_video;
  logic [23:0] pix_seen [256];
  int xo = 0;
  int failures = 0;
  int samples_checked = 0;

  always #10 ref_clk = ~ref_clk;

  pattern_gen_ctrl #(.H_ACTIVE(256), .V_ACTIVE(256)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_video(rx_video),
    .frame_start(frame_start), .tx_video(tx_video));

  always @(negedge ref_clk)
    if (tx_video.de === 1'b1)
    begin
      pix_seen[xo] = tx_video.pix;
      xo = xo + 1;
    end
    else
      xo = 0;

  task automatic chk(input string n, input logic [23:0] e,
    input logic [23:0] s);
    samples_checked++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk("reg_rdata", {16'h0, e}, {16'h0, reg_rdata});
  endtask

  // Lines are shorter than the active width where only one or two pixels matter.
  task automatic frame(input int nl, input int len);
    @(posedge ref_clk);
    frame_start <= 1'b1;
    rx_video.vs <= 1'b1;
    @(posedge ref_clk);
    frame_start <= 1'b0;
    rx_video.vs <= 1'b0;
    repeat (nl)
    begin
      for (int i = 0; i < len; i++)
      begin
        @(posedge ref_clk);
        rx_video.de <= 1'b1;
        rx_video.hs <= 1'b0;
      end
      @(posedge ref_clk);
      rx_video.de <= 1'b0;
      rx_video.hs <= 1'b1;
      repeat (3) @(posedge ref_clk);
    end
  endtask

  function automatic logic [23:0] exp_pix(input logic [3:0] c,
    input logic [7:0] x, input logic [7:0] y, input logic inv);
    logic [23:0] p;
    case (c)
      4'h1: p = 24'hffffff;
      4'h2: p = 24'h000000;
      4'h3: p = 24'hff0000;
      4'h4: p = 24'h00ff00;
      4'h5: p = 24'h0000ff;
      4'h6: p = {x, x, x};
      4'h7: p = {x, 16'h0};
      4'h8: p = {8'h0, x, 8'h0};
      4'h9: p = {16'h0, x};
      4'ha: p = {y, y, y};
      4'hb: p = {y, 16'h0};
      4'hc: p = {8'h0, y, 8'h0};
      default: p = {16'h0, y};
    endcase
    return inv ? ~p : p;
  endfunction

  task automatic t_reset;
    rd_chk(8'h64, 8'h10);
    rd_chk(8'h65, 8'h00);
    rd_chk(8'h70, 8'h00);
    rd_chk(8'h69, 8'h3c);
    frame(1, 8);
    chk("copied pixel", 24'h5a5a5a, pix_seen[3]);
    $display("test reset done");
  endtask

  task automatic t_codes;
    logic [23:0] e;
    for (int inv = 0; inv < 2; inv++)
      for (int c = 1; c < 14; c++)
      begin
        wr(8'h65, {6'h0, inv[0], 1'b0});
        // Reserved codes are never written, and the loop-through
        // transmitter sits outside this block, taken as powered down.
        wr(8'h64, {c[3:0], 4'h1});
        frame(9, 201);
        e = exp_pix(c[3:0], 8'hc8, 8'h08, inv[0]);
        chk("code pixel", e, pix_seen[200]);
      end
    $display("test codes done");
  endtask

  task automatic t_bars;
    logic [23:0] bars [8] = '{24'hffffff, 24'hffff00, 24'h00ffff,
      24'h00ff00, 24'hff00ff, 24'hff0000, 24'h0000ff, 24'h000000};
    wr(8'h65, 8'h00);
    wr(8'h64, 8'h15);
    frame(1, 256);
    for (int i = 0; i < 8; i++)
      chk("bar", bars[i], pix_seen[i * 32 + 16]);
    wr(8'h64, 8'h1d);
    frame(1, 16);
    chk("compliance dark", 24'h000000, pix_seen[0]);
    chk("compliance light", 24'hffffff, pix_seen[8]);
    wr(8'h64, 8'he1);
    frame(1, 4);
    chk("band", 24'hffff00, pix_seen[0]);
    wr(8'h64, 8'he3);
    frame(1, 4);
    chk("band reversed", 24'h0000ff, pix_seen[0]);
    $display("test bars done");
  endtask

  task automatic t_scroll;
    wr(8'h69, 8'h02);
    wr(8'h65, 8'h01);
    wr(8'h64, 8'h51);
    frame(1, 4);
    chk("scroll first", 24'hffffff, pix_seen[0]);
    frame(1, 4);
    chk("scroll step", 24'h000000, pix_seen[0]);
    rd_chk(8'h6a, 8'h21);
    wr(8'h65, 8'h00);
    rd_chk(8'h6a, 8'h51);
    frame(1, 4);
    chk("select back", 24'h0000ff, pix_seen[0]);
    wr(8'h64, 8'h50);
    frame(1, 4);
    chk("stopped copy", 24'h5a5a5a, pix_seen[0]);
    $display("test scroll done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_codes;
    t_bars;
    t_scroll;
    wrap_up;
  end

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    failures++;
    $display("unexpected run length expected done seen running");
    wrap_up;
  end
endmodule
